/* hdl/csb_map.svh */
`ifndef CSB_MAP_SVH
`define CSB_MAP_SVH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define CSB_OFS_CHG_SHORT 8'h09
`define CSB_OFS_BALANCE 8'h0a
`define CSB_OFS_NVM_CTRL 8'h0b
`define CSB_RST_CHG_SHORT 8'h00
`define CSB_RST_BALANCE 8'h00
`define CSB_RST_NVM_CTRL 8'h00
`define CSB_NVM_WRITE_KEY 8'h41
`define CSB_NVM_PREREAD_KEY 8'h62

// ----------------------------------------
// field positions
// ----------------------------------------
`define CSB_DSEL_HI 7
`define CSB_DSEL_LO 4
`define CSB_TRIP_HI 3
`define CSB_TRIP_LO 0
`define CSB_MODE_HI 7
`define CSB_MODE_LO 6
`define CSB_TSEL_HI 5
`define CSB_TSEL_LO 4
`define CSB_VSEL_HI 3
`define CSB_VSEL_LO 0

// ----------------------------------------
// balance modes
// ----------------------------------------
`define CSB_MODE_OFF 2'h0
`define CSB_MODE_ALWAYS 2'h1
`define CSB_MODE_CHG 2'h2
`define CSB_MODE_CHG_TMR 2'h3

// ----------------------------------------
// thresholds, mV
// ----------------------------------------
`define CSB_TRIP_BASE_LO 11'h00a
`define CSB_TRIP_STEP_LO 11'h005
`define CSB_TRIP_BASE_HI 11'h032
`define CSB_TRIP_STEP_HI 11'h019
`define CSB_CBV_TOP_MV 13'hf3c
`define CSB_CBV_STEP_MV 13'h064

// ----------------------------------------
// timing
// ----------------------------------------
`define CSB_CLK_MHZ 25
`define CSB_DLY_STEP_US 60
`define CSB_DLY_STEP_CYC (`CSB_DLY_STEP_US * `CSB_CLK_MHZ)
`define CSB_SEC_CYC (`CSB_CLK_MHZ * 1000000)
`define CSB_HOUR_SEC 3600
`define CSB_I2C_ACK_BITS 4'h8

`endif

/* hdl/csb_pkg.sv */
`default_nettype none
package csb_pkg;
  typedef enum logic [1:0] {BAL_IDLE, BAL_RUN, BAL_DONE} csb_bal_st_t;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_PTR, I2C_WR, I2C_RD}
    csb_i2c_st_t;
endpackage
`default_nettype wire

/* hdl/csb_reg_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface csb_reg_if;
  logic wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport link_side (output wr_stb, output addr, output wdata,
    input rdata);
  modport regs_side (input wr_stb, input addr, input wdata,
    output rdata);
endinterface
`default_nettype wire

/* hdl/csb_i2c_slave.sv */
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"
module csb_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // pins
  input wire logic i_port_en,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  // register side
  csb_reg_if.link_side bus
);
  csb_pkg::csb_i2c_st_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr;
  logic ack_ff, nxt_ack, nack_ff, nxt_nack, oe_ff, nxt_oe, wr_ff, nxt_wr;
  logic scl_q_ff, sda_q_ff, scl, sda, start, stop, rise, fall;

  assign o_sda_oe = oe_ff;
  assign bus.wr_stb = wr_ff;
  assign bus.addr = ptr_ff;
  assign bus.wdata = sh_ff;

  // ----------------------------------------
  // bit engine
  // ----------------------------------------
  always_comb begin
    scl = i_port_en ? i_scl : 1'b1;
    sda = i_port_en ? i_sda : 1'b1;
    start = scl & scl_q_ff & sda_q_ff & ~sda;
    stop = scl & scl_q_ff & ~sda_q_ff & sda;
    rise = scl & ~scl_q_ff;
    fall = ~scl & scl_q_ff;
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_ack = ack_ff;
    nxt_nack = nack_ff;
    nxt_oe = oe_ff;
    nxt_wr = 1'b0;
    if (!i_port_en || stop) begin
      nxt_st = csb_pkg::I2C_IDLE;
      nxt_oe = 1'b0;
      nxt_ack = 1'b0;
    end else if (start) begin
      nxt_st = csb_pkg::I2C_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
      nxt_ack = 1'b0;
    end else if (rise && st_ff != csb_pkg::I2C_IDLE) begin
      if (ack_ff) begin
        nxt_nack = sda;
      end else begin
        nxt_cnt = cnt_ff + 4'h1;
        if (st_ff != csb_pkg::I2C_RD) begin
          nxt_sh = {sh_ff[6:0], sda};
        end
      end
    end else if (fall && st_ff != csb_pkg::I2C_IDLE) begin
      if (ack_ff) begin
        nxt_ack = 1'b0;
        nxt_cnt = 4'h0;
        nxt_oe = 1'b0;
        if (st_ff == csb_pkg::I2C_RD) begin
          if (nack_ff) begin
            nxt_st = csb_pkg::I2C_IDLE;
          end else begin
            nxt_sh = bus.rdata;
            nxt_oe = ~bus.rdata[7];
          end
        end
      end else if (cnt_ff == `CSB_I2C_ACK_BITS) begin
        nxt_ack = 1'b1;
        nxt_oe = 1'b1;
        unique case (st_ff)
          csb_pkg::I2C_ADDR: begin
            if (sh_ff[7:1] == DEV_ADDR) begin
              nxt_st = sh_ff[0] ? csb_pkg::I2C_RD : csb_pkg::I2C_PTR;
            end else begin
              nxt_st = csb_pkg::I2C_IDLE;
              nxt_ack = 1'b0;
              nxt_oe = 1'b0;
            end
          end
          csb_pkg::I2C_PTR: begin
            nxt_ptr = sh_ff;
            nxt_st = csb_pkg::I2C_WR;
          end
          csb_pkg::I2C_WR: nxt_wr = 1'b1;
          csb_pkg::I2C_RD: nxt_oe = 1'b0;
          csb_pkg::I2C_IDLE: nxt_st = csb_pkg::I2C_IDLE;
        endcase
      end else if (st_ff == csb_pkg::I2C_RD) begin
        nxt_sh = {sh_ff[6:0], 1'b0};
        nxt_oe = ~sh_ff[6];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_ff <= csb_pkg::I2C_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      ack_ff <= 1'b0;
      nack_ff <= 1'b0;
      oe_ff <= 1'b0;
      wr_ff <= 1'b0;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      ack_ff <= nxt_ack;
      nack_ff <= nxt_nack;
      oe_ff <= nxt_oe;
      wr_ff <= nxt_wr;
      scl_q_ff <= scl;
      sda_q_ff <= sda;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_port_off;
    @(posedge i_mclk) disable iff (i_sys_rst)
      !i_port_en |=> !o_sda_oe;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("data line driven while port disabled");
endmodule
`default_nettype wire

/* hdl/csb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"
// What this block does
// - upper nibble picks 120-960 us delay
// - lower nibble picks trip level per range
// - gain range bit selects trip level set
// - delay doubled while balancing runs
// - mode 00 keeps balancing off
// - mode 01 runs until timeout, rearms below
// - mode 10 balances only with charger present
// - mode 11 needs charger replug after timeout
// - timer starts when bleeding actually starts
// - timeout 1/2/4/8 hours stops balancing in modes 01 and 11
// - start voltage 3.9 V down to 2.4 V
// - control 0x41 enables nonvolatile writes
// - control 0x62 triggers a pre-read
// - control register resets to zero
// - serial pins live only with port enable
module csb_top #(
  parameter int NCELL = 10,
  parameter int CELL_W = 13,
  parameter int DLY_STEP_CYC = `CSB_DLY_STEP_CYC,
  parameter int SEC_CYC = `CSB_SEC_CYC,
  parameter int HOUR_SEC = `CSB_HOUR_SEC,
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // configuration port
  input wire logic i_config_port_enable,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // analog side
  input wire logic i_sense_gain_range,
  input wire logic signed [11:0] i_sense_mv,
  input wire logic [NCELL*CELL_W-1:0] i_cell_mv,
  input wire logic i_charger_det,
  input wire logic i_nvm_prog,
  // results
  output logic o_charge_short_circuit,
  output logic o_bal_active,
  output logic [NCELL-1:0] o_bleed,
  output logic o_nvm_write_en,
  output logic o_nvm_preread,
  output logic o_nvm_commit
);
  csb_reg_if rif ();
  csb_pkg::csb_bal_st_t bal_st_ff, nxt_bal_st;
  logic [7:0] short_cfg_ff, nxt_short_cfg, bal_cfg_ff, nxt_bal_cfg;
  logic [7:0] nvm_ctrl_ff, nxt_nvm_ctrl;
  logic [16:0] dly_cnt_ff, nxt_dly_cnt, dly_lim;
  logic [24:0] tick_cnt_ff, nxt_tick_cnt;
  logic [14:0] secs_ff, nxt_secs, tmo_lim;
  logic fault_ff, nxt_fault, act_ff, nxt_act, wen_ff, nxt_wen;
  logic pre_ff, nxt_pre, commit_ff, nxt_commit, prog_q_ff, sda_o_ff;
  logic [NCELL-1:0] bleed_ff, nxt_bleed, cell_at;
  logic [10:0] trip_mag;
  logic [12:0] sense_neg;
  logic [CELL_W-1:0] bal_thr;
  logic [3:0] dsel, tsel_steps;
  logic [1:0] mode;
  logic over, any_at, expired;
  csb_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_link (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_port_en(i_config_port_enable),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe(o_sda_oe),
    .bus(rif.link_side)
  );
  assign o_sda_o = sda_o_ff;
  assign o_charge_short_circuit = fault_ff;
  assign o_bal_active = act_ff;
  assign o_bleed = bleed_ff;
  assign o_nvm_write_en = wen_ff;
  assign o_nvm_preread = pre_ff;
  assign o_nvm_commit = commit_ff;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_comb begin
    nxt_short_cfg = short_cfg_ff;
    nxt_bal_cfg = bal_cfg_ff;
    nxt_nvm_ctrl = nvm_ctrl_ff;
    if (rif.wr_stb) begin
      unique case (rif.addr)
        `CSB_OFS_CHG_SHORT: nxt_short_cfg = rif.wdata;
        `CSB_OFS_BALANCE: nxt_bal_cfg = rif.wdata;
        `CSB_OFS_NVM_CTRL: nxt_nvm_ctrl = rif.wdata;
        default: nxt_nvm_ctrl = nvm_ctrl_ff;
      endcase
    end
    unique case (rif.addr)
      `CSB_OFS_CHG_SHORT: rif.rdata = short_cfg_ff;
      `CSB_OFS_BALANCE: rif.rdata = bal_cfg_ff;
      `CSB_OFS_NVM_CTRL: rif.rdata = nvm_ctrl_ff;
      default: rif.rdata = 8'h00;
    endcase
    nxt_wen = nxt_nvm_ctrl == `CSB_NVM_WRITE_KEY;
    nxt_pre = rif.wr_stb && rif.addr == `CSB_OFS_NVM_CTRL
      && rif.wdata == `CSB_NVM_PREREAD_KEY;
    // commit only when armed; a stray pin pulse is harmless
    nxt_commit = wen_ff & prog_q_ff & ~i_nvm_prog;
  end
  // ----------------------------------------
  // charge short-circuit qualifier
  // ----------------------------------------
  always_comb begin
    dsel = short_cfg_ff[`CSB_DSEL_HI:`CSB_DSEL_LO];
    // reserved code 0 behaves as the shortest delay
    tsel_steps = (dsel == 4'h0) ? 4'h1 : dsel;
    dly_lim = 17'((tsel_steps + 1) * DLY_STEP_CYC);
    if (bal_st_ff == csb_pkg::BAL_RUN) begin
      dly_lim = {dly_lim[15:0], 1'b0};
    end
    if (i_sense_gain_range) begin
      trip_mag = `CSB_TRIP_BASE_HI + 11'(`CSB_TRIP_STEP_HI
        * short_cfg_ff[`CSB_TRIP_HI:`CSB_TRIP_LO]);
    end else begin
      trip_mag = `CSB_TRIP_BASE_LO + 11'(`CSB_TRIP_STEP_LO
        * short_cfg_ff[`CSB_TRIP_HI:`CSB_TRIP_LO]);
    end
    sense_neg = 13'(-$signed({i_sense_mv[11], i_sense_mv}));
    over = $signed(sense_neg) >= $signed({2'b00, trip_mag});
    nxt_dly_cnt = dly_cnt_ff;
    if (!over) begin
      nxt_dly_cnt = 17'h00000;
    end else if (dly_cnt_ff < dly_lim) begin
      nxt_dly_cnt = dly_cnt_ff + 17'h00001;
    end
    nxt_fault = over && dly_cnt_ff >= dly_lim;
  end
  // ----------------------------------------
  // cell balancing
  // ----------------------------------------
  assign bal_thr = CELL_W'(`CSB_CBV_TOP_MV - `CSB_CBV_STEP_MV
    * bal_cfg_ff[`CSB_VSEL_HI:`CSB_VSEL_LO]);
  genvar g;
  generate
    for (g = 0; g < NCELL; g++) begin : g_cell
      assign cell_at[g] = i_cell_mv[g*CELL_W +: CELL_W] >= bal_thr;
    end
  endgenerate
  always_comb begin
    mode = bal_cfg_ff[`CSB_MODE_HI:`CSB_MODE_LO];
    any_at = |cell_at;
    tmo_lim = 15'(HOUR_SEC) << bal_cfg_ff[`CSB_TSEL_HI:`CSB_TSEL_LO];
    expired = secs_ff >= tmo_lim;
    nxt_bal_st = bal_st_ff;
    nxt_tick_cnt = tick_cnt_ff;
    nxt_secs = secs_ff;
    unique case (bal_st_ff)
      csb_pkg::BAL_IDLE: begin
        if ((mode == `CSB_MODE_ALWAYS && any_at)
            || (mode[1] && i_charger_det && any_at)) begin
          nxt_bal_st = csb_pkg::BAL_RUN;
          nxt_tick_cnt = 25'h0000000;
          nxt_secs = 15'h0000;
        end
      end
      csb_pkg::BAL_RUN: begin
        if (mode == `CSB_MODE_OFF) begin
          nxt_bal_st = csb_pkg::BAL_IDLE;
        end else if (mode[1] && !i_charger_det) begin
          nxt_bal_st = csb_pkg::BAL_IDLE;
        end else if (expired && mode != `CSB_MODE_CHG) begin
          nxt_bal_st = csb_pkg::BAL_DONE;
        end else if (tick_cnt_ff == 25'(SEC_CYC - 1)) begin
          nxt_tick_cnt = 25'h0000000;
          nxt_secs = secs_ff + 15'h0001;
        end else begin
          nxt_tick_cnt = tick_cnt_ff + 25'h0000001;
        end
      end
      csb_pkg::BAL_DONE: begin
        if (mode == `CSB_MODE_OFF || mode == `CSB_MODE_CHG
            || (mode == `CSB_MODE_ALWAYS && !any_at)
            || (mode == `CSB_MODE_CHG_TMR && !i_charger_det)) begin
          nxt_bal_st = csb_pkg::BAL_IDLE;
        end
      end
      default: nxt_bal_st = csb_pkg::BAL_IDLE;
    endcase
    nxt_act = nxt_bal_st == csb_pkg::BAL_RUN;
    nxt_bleed = nxt_act ? cell_at : '0;
  end
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      short_cfg_ff <= `CSB_RST_CHG_SHORT;
      bal_cfg_ff <= `CSB_RST_BALANCE;
      nvm_ctrl_ff <= `CSB_RST_NVM_CTRL;
      bal_st_ff <= csb_pkg::BAL_IDLE;
      dly_cnt_ff <= 17'h00000;
      tick_cnt_ff <= 25'h0000000;
      secs_ff <= 15'h0000;
      fault_ff <= 1'b0;
      act_ff <= 1'b0;
      bleed_ff <= '0;
      wen_ff <= 1'b0;
      pre_ff <= 1'b0;
      commit_ff <= 1'b0;
      prog_q_ff <= 1'b0;
      sda_o_ff <= 1'b0;
    end else begin
      short_cfg_ff <= nxt_short_cfg;
      bal_cfg_ff <= nxt_bal_cfg;
      nvm_ctrl_ff <= nxt_nvm_ctrl;
      bal_st_ff <= nxt_bal_st;
      dly_cnt_ff <= nxt_dly_cnt;
      tick_cnt_ff <= nxt_tick_cnt;
      secs_ff <= nxt_secs;
      fault_ff <= nxt_fault;
      act_ff <= nxt_act;
      bleed_ff <= nxt_bleed;
      wen_ff <= nxt_wen;
      pre_ff <= nxt_pre;
      commit_ff <= nxt_commit;
      prog_q_ff <= i_nvm_prog;
      sda_o_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_fault_clear;
    @(posedge i_mclk) disable iff (i_sys_rst) !over |=> !fault_ff;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault held without short condition");
  property p_fault_delay;
    @(posedge i_mclk) disable iff (i_sys_rst)
      $rose(fault_ff) |-> $past(dly_cnt_ff) >= $past(dly_lim);
  endproperty
  a_fault_delay: assert property (p_fault_delay)
    else $error("fault raised before delay ran out");
  property p_mode_off;
    @(posedge i_mclk) disable iff (i_sys_rst)
      mode == `CSB_MODE_OFF |=> !act_ff && bleed_ff == '0;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("balancing active while disabled");
  property p_chg_removed;
    @(posedge i_mclk) disable iff (i_sys_rst)
      mode[1] && !i_charger_det |=> !act_ff;
  endproperty
  a_chg_removed: assert property (p_chg_removed)
    else $error("balancing without charger");
  property p_replug;
    @(posedge i_mclk) disable iff (i_sys_rst)
      bal_st_ff == csb_pkg::BAL_DONE && mode == `CSB_MODE_CHG_TMR
      && i_charger_det |=> !act_ff;
  endproperty
  a_replug: assert property (p_replug)
    else $error("balancing resumed without charger replug");
  property p_timer_start;
    @(posedge i_mclk) disable iff (i_sys_rst)
      $rose(act_ff) |-> secs_ff == 15'h0000 && tick_cnt_ff == 25'h0000000;
  endproperty
  a_timer_start: assert property (p_timer_start)
    else $error("timer not cleared at balance start");
  property p_timeout;
    @(posedge i_mclk) disable iff (i_sys_rst)
      act_ff && expired && mode == `CSB_MODE_ALWAYS |=> !act_ff;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("balancing past timeout");
  property p_nvm_key;
    @(posedge i_mclk) disable iff (i_sys_rst)
      rif.wr_stb && rif.addr == `CSB_OFS_NVM_CTRL |=>
      ##1 wen_ff == (rif.wdata == `CSB_NVM_WRITE_KEY) || rif.wr_stb;
  endproperty
  a_nvm_key: assert property (p_nvm_key)
    else $error("write enable disagrees with control key");
  property p_preread;
    @(posedge i_mclk) disable iff (i_sys_rst)
      pre_ff |-> nvm_ctrl_ff == `CSB_NVM_PREREAD_KEY ##1 !pre_ff
      || rif.wr_stb;
  endproperty
  a_preread: assert property (p_preread)
    else $error("pre-read pulse without its key");
  property p_rst_zero;
    @(posedge i_mclk) disable iff (i_sys_rst)
      $past(i_sys_rst) |-> nvm_ctrl_ff == 8'h00 && !wen_ff;
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("control register not zero after reset");
endmodule
`default_nettype wire

/* testbench/csb_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module csb_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  // clock
  input wire logic i_mclk,
  // serial pins
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  // ------
  // open-drain wire, pulled up when released
  // ------
  logic sda_low = 1'b0;
  initial o_scl = 1'b1;
  assign o_sda = ~(sda_low | i_sda_oe);

  task automatic w(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // half period of 5 clocks keeps above the 4 clock minimum
  task automatic bit_out(input logic b);
    sda_low <= ~b;
    w(5);
    o_scl <= 1'b1;
    w(5);
    o_scl <= 1'b0;
    w(2);
  endtask
  task automatic bit_in(output logic b);
    sda_low <= 1'b0;
    w(5);
    o_scl <= 1'b1;
    w(3);
    b = o_sda;
    w(2);
    o_scl <= 1'b0;
    w(2);
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask
  // also serves as repeated start: release, clock up, pull down
  task automatic start();
    w(1);
    sda_low <= 1'b0;
    w(3);
    o_scl <= 1'b1;
    w(5);
    sda_low <= 1'b1;
    w(5);
    o_scl <= 1'b0;
    w(2);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    w(5);
    o_scl <= 1'b1;
    w(5);
    sda_low <= 1'b0;
    w(5);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
      output logic ok);
    logic k0, k1, k2;
    start();
    byte_out({DEV_ADDR, 1'b0}, k0);
    byte_out(a, k1);
    byte_out(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
      output logic ok);
    logic k0, k1, k2, b;
    start();
    byte_out({DEV_ADDR, 1'b0}, k0);
    byte_out(a, k1);
    start();
    byte_out({DEV_ADDR, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(1'b1);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ------
  // pins and counters
  // ------
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic port_en = 1'b1;
  logic rng = 1'b0;
  logic chg = 1'b0;
  logic prog = 1'b0;
  logic signed [11:0] sense = 12'sh000;
  logic [12:0] cell0 = 13'h000;
  logic [12:0] cell1 = 13'h000;
  logic scl, sda, sda_o, sda_oe, flt, bal, wen, pre, com;
  logic [1:0] bleed;
  int error_cnt = 0;
  int samples_checked = 0;
  int n_pre = 0;
  int n_com = 0;

  csb_top #(.NCELL(2), .DLY_STEP_CYC(4), .SEC_CYC(4), .HOUR_SEC(3)) DUT (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_config_port_enable(port_en), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_sense_gain_range(rng),
    .i_sense_mv(sense), .i_cell_mv({cell1, cell0}), .i_charger_det(chg),
    .i_nvm_prog(prog), .o_charge_short_circuit(flt), .o_bal_active(bal),
    .o_bleed(bleed), .o_nvm_write_en(wen), .o_nvm_preread(pre),
    .o_nvm_commit(com));
  csb_host_model host (.i_mclk(i_mclk), .i_sda_oe(sda_oe), .o_scl(scl),
    .o_sda(sda));

  initial forever #20 i_mclk = ~i_mclk;
  // single-cycle pulses are counted away from their launch edge
  always @(negedge i_mclk) begin
    if (pre === 1'b1) n_pre++;
    if (com === 1'b1) n_com++;
  end

  // ------
  // helpers
  // ------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.write_reg(a, d, ok);
    chk(ok, 1'b1);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    logic ok;
    host.read_reg(a, d, ok);
    chk(ok, 1'b1);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_reset();
    logic [7:0] d;
    rreg(8'h0b, d);
    chk(d, 8'h00);
    chk(wen, 1'b0);
    chk(sda_o, 1'b0);
    @(posedge i_mclk);
    cell0 <= 13'hf3c;
    chg <= 1'b1;
    at(20);
    chk({bal, bleed}, 3'h0);
    wreg(8'h09, 8'ha5);
    rreg(8'h09, d);
    chk(d, 8'ha5);
    wreg(8'h0c, 8'h41);
    chk(wen, 1'b0);
    @(posedge i_mclk);
    chg <= 1'b0;
    $display("test reset done");
  endtask

  task automatic t_nvm();
    logic ok;
    logic [7:0] d;
    @(posedge i_mclk);
    port_en <= 1'b0;
    host.write_reg(8'h0b, 8'h41, ok);
    chk(ok, 1'b0);
    chk(wen, 1'b0);
    @(posedge i_mclk);
    port_en <= 1'b1;
    wreg(8'h0b, 8'h41);
    at(2);
    chk(wen, 1'b1);
    chk(n_pre, 0);
    // program pin high then low commits the armed data
    @(posedge i_mclk);
    prog <= 1'b1;
    at(3);
    @(posedge i_mclk);
    prog <= 1'b0;
    at(3);
    chk(n_com, 1);
    wreg(8'h0b, 8'h62);
    at(2);
    chk(n_pre, 1);
    chk(wen, 1'b0);
    rreg(8'h0b, d);
    chk(d, 8'h62);
    wreg(8'h0b, 8'h00);
    @(posedge i_mclk);
    prog <= 1'b1;
    at(3);
    @(posedge i_mclk);
    prog <= 1'b0;
    at(3);
    chk(n_com, 1);
    $display("test nvm done");
  endtask

  task automatic one_short(input logic r, input logic [3:0] dc,
      input logic [3:0] tc, input int mv, input int lim, input logic exp);
    @(posedge i_mclk);
    rng <= r;
    wreg(8'h09, {dc, tc});
    @(posedge i_mclk);
    sense <= 12'(mv);
    at(lim - 3);
    chk(flt, 1'b0);
    at(6);
    chk(flt, exp);
    @(posedge i_mclk);
    sense <= 12'sh000;
    at(3);
    chk(flt, 1'b0);
  endtask

  task automatic t_short();
    one_short(1'b0, 4'h2, 4'h3, -25, 12, 1'b1);
    one_short(1'b0, 4'h2, 4'h3, -24, 12, 1'b0);
    one_short(1'b0, 4'hf, 4'hf, -85, 64, 1'b1);
    one_short(1'b1, 4'h1, 4'h0, -50, 8, 1'b1);
    one_short(1'b1, 4'h1, 4'h0, -49, 8, 1'b0);
    one_short(1'b1, 4'h1, 4'hf, -425, 8, 1'b1);
    one_short(1'b1, 4'h1, 4'hf, -424, 8, 1'b0);
    // a one-cycle gap must restart the qualification count
    // high range, trip code f and delay code 1 still hold here
    @(posedge i_mclk);
    sense <= -12'sh1a9;
    at(6);
    @(posedge i_mclk);
    sense <= 12'sh000;
    @(posedge i_mclk);
    sense <= -12'sh1a9;
    at(8);
    chk(flt, 1'b0);
    at(8);
    chk(flt, 1'b1);
    @(posedge i_mclk);
    sense <= 12'sh000;
    $display("test short done");
  endtask

  task automatic t_mode01();
    int thr;
    for (int t = 0; t < 4; t++) begin
      thr = 32'hf3c - 32'h1f4 * t;
      wreg(8'h0a, {2'h1, 2'(t), 4'(5 * t)});
      @(posedge i_mclk);
      cell0 <= 13'(thr - 1);
      cell1 <= 13'(thr - 1);
      at(30);
      chk(bal, 1'b0);
      @(posedge i_mclk);
      cell0 <= 13'(thr);
      at(3);
      chk(bleed, 2'h1);
      at((12 << t) - 6);
      chk(bal, 1'b1);
      at(8);
      chk(bal, 1'b0);
      at(20);
      chk(bal, 1'b0);
      @(posedge i_mclk);
      cell0 <= 13'(thr - 1);
      at(3);
      @(posedge i_mclk);
      cell1 <= 13'(thr);
      at(3);
      chk(bleed, 2'h2);
      @(posedge i_mclk);
      cell0 <= 13'h7d0;
      cell1 <= 13'h7d0;
    end
    $display("test mode01 done");
  endtask

  task automatic t_charger();
    wreg(8'h0a, 8'h80);
    @(posedge i_mclk);
    cell0 <= 13'hf3c;
    at(20);
    chk(bal, 1'b0);
    @(posedge i_mclk);
    chg <= 1'b1;
    at(3);
    chk(bal, 1'b1);
    wreg(8'h09, 8'h10);
    chk(bal, 1'b1);
    // qualification stretched while bleeding runs
    @(posedge i_mclk);
    sense <= -12'sh032;
    at(11);
    chk(flt, 1'b0);
    at(8);
    chk(flt, 1'b1);
    @(posedge i_mclk);
    sense <= 12'sh000;
    chg <= 1'b0;
    at(3);
    chk({bal, bleed}, 3'h0);
    wreg(8'h0a, 8'hc0);
    @(posedge i_mclk);
    chg <= 1'b1;
    at(3);
    chk(bal, 1'b1);
    at(20);
    chk(bal, 1'b0);
    at(20);
    chk(bal, 1'b0);
    @(posedge i_mclk);
    chg <= 1'b0;
    at(3);
    @(posedge i_mclk);
    chg <= 1'b1;
    at(3);
    chk(bal, 1'b1);
    @(posedge i_mclk);
    chg <= 1'b0;
    at(3);
    chk(bal, 1'b0);
    $display("test charger done");
  endtask

  // ------
  // main sequence and watchdog
  // ------
  initial begin
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_nvm();
    t_short();
    t_mode01();
    t_charger();
    final_report();
  end
  initial begin
    repeat (80000) @(posedge i_mclk);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
